// File: pscl_pkg.sv
// Shared constants and types for the port special control register slice
package pscl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices and APB byte addresses (word per index)
    localparam int PSCL_ADDR_W = 12;
    localparam logic [7:0] PSCL_IDX_SPECIAL = 8'h1B;
    localparam logic [7:0] PSCL_IDX_CABLE = 8'h1C;
    localparam logic [PSCL_ADDR_W-1:0] PSCL_ADDR_SPECIAL =
        {2'h0, PSCL_IDX_SPECIAL, 2'h0};
    localparam logic [PSCL_ADDR_W-1:0] PSCL_ADDR_CABLE =
        {2'h0, PSCL_IDX_CABLE, 2'h0};

    ////////////////////////////////////////////////////////////////////////
    // Field positions in the special control word
    localparam int PSCL_XSRC_BIT = 15;
    localparam int PSCL_XEN_BIT = 14;
    localparam int PSCL_XSTATE_BIT = 13;
    localparam int PSCL_HB_BIT = 11;
    localparam int PSCL_FF_BIT = 5;
    localparam int PSCL_POL_BIT = 4;

    // Field position and width of the cable length estimate
    localparam int PSCL_CBL_LSB = 12;
    localparam int PSCL_CBL_W = 4;

    // Bits of the special word that hold state; all others read zero
    localparam logic [15:0] PSCL_SPECIAL_USED = 16'hE830;
    localparam logic [15:0] PSCL_CABLE_USED = 16'hF000;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic PSCL_XSRC_RST = 1'b0;
    localparam logic PSCL_XEN_RST = 1'b0;
    localparam logic PSCL_XSTATE_RST = 1'b0;
    localparam logic PSCL_HB_RST = 1'b0;
    localparam logic PSCL_POL_RST = 1'b0;
    localparam logic [3:0] PSCL_CBL_RST = 4'h0;
    localparam logic [31:0] PSCL_RDATA_RST = 32'h0000_0000;

    // Width of the group of status inputs that cross in from the PHY
    localparam int PSCL_STAT_W = 9;

    ////////////////////////////////////////////////////////////////////////
    // Crossover modes driven to the PHY analog front end
    typedef enum logic [1:0]
    {
        PSCL_MDIX_STRAIGHT = 2'b00,
        PSCL_MDIX_CROSS = 2'b01,
        PSCL_MDIX_AUTO = 2'b10
    } pscl_mdix_t;

endpackage

// File: pscl_sync.sv
// Two-stage synchroniser for a group of slow status levels
`timescale 1ns/1ns
module pscl_sync #(
    parameter int WIDTH = 1
)
(
    input wire logic clock,
    input wire logic clock_enable,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    ////////////////////////////////////////////////////////////////////////
    // One pair of flops per bit; no reset so straps are seen during reset
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            logic stage1;
            logic stage2;
            // First stage feeds only the second stage
            always_ff @(posedge clock)
            begin
                if (clock_enable)
                begin
                    stage1 <= async_in[i];
                    stage2 <= stage1;
                end
            end
            assign sync_out[i] = stage2;
        end
    endgenerate

endmodule

// File: pscl_mdix_decode.sv
// Decode of the crossover control bits into a crossover mode
`timescale 1ns/1ns
module pscl_mdix_decode
(
    input wire logic crossover_source_select,
    input wire logic crossover_auto_enable,
    input wire logic crossover_manual_state,
    output pscl_pkg::pscl_mdix_t mode,
    output logic reserved_combo
);

    ////////////////////////////////////////////////////////////////////////
    // Manual table; the reserved code falls back to automatic detection
    always_comb
    begin
        mode = pscl_pkg::PSCL_MDIX_AUTO;
        reserved_combo = 1'b0;
        if (crossover_source_select)
        begin
            unique case ({crossover_auto_enable, crossover_manual_state})
                2'b00: mode = pscl_pkg::PSCL_MDIX_STRAIGHT;
                2'b01: mode = pscl_pkg::PSCL_MDIX_CROSS;
                2'b10: mode = pscl_pkg::PSCL_MDIX_AUTO;
                2'b11: reserved_combo = 1'b1; // Safest: keep auto
            endcase
        end
    end

endmodule

// File: pscl_regs.sv
// Port special control and cable length registers behind an APB slave
//
// Contract
// - source bit 0 auto, 1 follows bits 14/13
// - manual table: straight, crossover, automatic
// - bit 11 one disables heartbeat, resets 0
// - bit 5 enables far-end fault signalling
// - far-end fault resets to fiber strap value
// - bit 4 shows 10BASE-T polarity, resets 0
// - crossover and heartbeat bits survive soft reset
// - cable bits 15:12 show estimate, reset zero
// - estimate only on healthy linked 100BASE-TX
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
module pscl_regs
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    input wire logic port_soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fx_mode,
    input wire logic rx_polarity_reversed,
    input wire logic link_up,
    input wire logic speed_100tx,
    input wire logic cable_fault,
    input wire logic [3:0] cable_length_raw,
    output pscl_pkg::pscl_mdix_t crossover_mode,
    output logic heartbeat_test_active,
    output logic far_fault_signalling,
    output logic crossover_reserved
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic crossover_source_select;
    logic crossover_auto_enable;
    logic crossover_manual_state;
    logic heartbeat_test_disable;
    logic far_fault_enable;
    logic tenbase_polarity_flag;
    logic [3:0] cable_length_estimate;

    ////////////////////////////////////////////////////////////////////////
    // Status levels from the PHY core cross in through two flops
    logic [8:0] stat_raw;
    logic [8:0] stat_s;
    logic fx_mode_s;
    logic pol_s;
    logic link_s;
    logic speed_s;
    logic fault_s;
    logic [3:0] raw_len_s;

    assign stat_raw = {cable_length_raw, cable_fault, speed_100tx, link_up,
                       rx_polarity_reversed, fx_mode};

    pscl_sync #(
        .WIDTH(pscl_pkg::PSCL_STAT_W)
    ) u_sync (
        .clock(clock),
        .clock_enable(clock_enable),
        .async_in(stat_raw),
        .sync_out(stat_s)
    );

    assign fx_mode_s = stat_s[0];
    assign pol_s = stat_s[1];
    assign link_s = stat_s[2];
    assign speed_s = stat_s[3];
    assign fault_s = stat_s[4];
    assign raw_len_s = stat_s[8:5];

    ////////////////////////////////////////////////////////////////////////
    // APB decode; one wait state so read data can come from a flop
    logic access_phase;
    logic hit_special;
    logic hit_cable;
    logic hit_any;
    logic wr_fire;
    logic wr_special_hi;
    logic wr_special_lo;
    logic next_pready;

    assign access_phase = psel & penable;
    assign hit_special = (paddr == pscl_pkg::PSCL_ADDR_SPECIAL);
    assign hit_cable = (paddr == pscl_pkg::PSCL_ADDR_CABLE);
    assign hit_any = hit_special | hit_cable;
    assign wr_fire = access_phase & pready & pwrite;
    assign wr_special_hi = wr_fire & hit_special & pstrb[1];
    assign wr_special_lo = wr_fire & hit_special & pstrb[0];
    assign next_pready = access_phase & ~pready;

    // Read words; reserved and pattern bits always read zero
    logic [15:0] special_word;
    logic [15:0] cable_word;
    logic [31:0] next_prdata;

    assign special_word = {crossover_source_select, crossover_auto_enable,
                           crossover_manual_state, 1'b0,
                           heartbeat_test_disable, 5'h00,
                           far_fault_enable, tenbase_polarity_flag,
                           4'h0};
    assign cable_word = {cable_length_estimate, 12'h000};
    assign next_prdata = hit_special ? {16'h0000, special_word} :
                         hit_cable ? {16'h0000, cable_word} :
                         pscl_pkg::PSCL_RDATA_RST;

    ////////////////////////////////////////////////////////////////////////
    // Bus answer flops; reset wins over a frozen clock enable
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= pscl_pkg::PSCL_RDATA_RST;
        end
        else if (clock_enable)
        begin
            pready <= next_pready;
            pslverr <= next_pready & ~hit_any;
            prdata <= (next_pready & ~pwrite) ? next_prdata :
                      pscl_pkg::PSCL_RDATA_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossover and heartbeat bits: cleared only by the chip-level reset
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            crossover_source_select <= pscl_pkg::PSCL_XSRC_RST;
            crossover_auto_enable <= pscl_pkg::PSCL_XEN_RST;
            crossover_manual_state <= pscl_pkg::PSCL_XSTATE_RST;
            heartbeat_test_disable <= pscl_pkg::PSCL_HB_RST;
        end
        else if (clock_enable && wr_special_hi)
        begin
            // Soft reset is deliberately ignored here
            crossover_source_select <= pwdata[pscl_pkg::PSCL_XSRC_BIT];
            crossover_auto_enable <= pwdata[pscl_pkg::PSCL_XEN_BIT];
            crossover_manual_state <= pwdata[pscl_pkg::PSCL_XSTATE_BIT];
            heartbeat_test_disable <= pwdata[pscl_pkg::PSCL_HB_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Far-end fault enable: strap default on either reset, soft one wins
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            far_fault_enable <= fx_mode_s;
        end
        else if (clock_enable)
        begin
            if (port_soft_reset)
            begin
                far_fault_enable <= fx_mode_s;
            end
            else if (wr_special_lo)
            begin
                far_fault_enable <= pwdata[pscl_pkg::PSCL_FF_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status capture; estimate is forced to zero unless a fault-free 100BASE-TX link is up
    logic cable_qualified;
    logic [3:0] next_cable_length;

    assign cable_qualified = link_s & speed_s & ~fault_s;
    assign next_cable_length = cable_qualified ? raw_len_s :
                               pscl_pkg::PSCL_CBL_RST;

    always_ff @(posedge clock)
    begin
        if (reset || (clock_enable && port_soft_reset))
        begin
            tenbase_polarity_flag <= pscl_pkg::PSCL_POL_RST;
            cable_length_estimate <= pscl_pkg::PSCL_CBL_RST;
        end
        else if (clock_enable)
        begin
            tenbase_polarity_flag <= pol_s;
            cable_length_estimate <= next_cable_length;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossover mode decode, registered before leaving the block
    pscl_pkg::pscl_mdix_t next_mode;
    logic next_reserved;

    pscl_mdix_decode u_decode (
        .crossover_source_select(crossover_source_select),
        .crossover_auto_enable(crossover_auto_enable),
        .crossover_manual_state(crossover_manual_state),
        .mode(next_mode),
        .reserved_combo(next_reserved)
    );

    // Outputs lag the register bits by one cycle
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            crossover_mode <= pscl_pkg::PSCL_MDIX_AUTO;
            heartbeat_test_active <= 1'b1;
            far_fault_signalling <= 1'b0;
            crossover_reserved <= 1'b0;
        end
        else if (clock_enable)
        begin
            crossover_mode <= next_mode;
            heartbeat_test_active <= ~heartbeat_test_disable;
            far_fault_signalling <= far_fault_enable;
            crossover_reserved <= next_reserved;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the behaviour above
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    chk_auto_source_zero: assert property (
        clock_enable && !crossover_source_select |=>
        crossover_mode == pscl_pkg::PSCL_MDIX_AUTO)
        else $error("source 0 did not give auto crossover");

    chk_manual_straight: assert property (
        clock_enable && crossover_source_select &&
        !crossover_auto_enable && !crossover_manual_state |=>
        crossover_mode == pscl_pkg::PSCL_MDIX_STRAIGHT)
        else $error("manual 00 did not give straight");

    chk_manual_cross: assert property (
        clock_enable && crossover_source_select &&
        !crossover_auto_enable && crossover_manual_state |=>
        crossover_mode == pscl_pkg::PSCL_MDIX_CROSS)
        else $error("manual 01 did not give crossover");

    chk_heartbeat_write: assert property (
        clock_enable && wr_special_hi && pwdata[pscl_pkg::PSCL_HB_BIT]
        ##1 clock_enable |=> !heartbeat_test_active)
        else $error("heartbeat stayed on after disable write");

    chk_far_fault_out: assert property (
        clock_enable && far_fault_enable |=> far_fault_signalling)
        else $error("far fault enable not driven out");

    // Waits four reset edges: the sync flops have no reset of their own
    chk_far_fault_strap: assert property (
        @(posedge clock) disable iff (1'b0)
        $past(reset) && $past(reset, 4) |->
        far_fault_enable == $past(fx_mode_s))
        else $error("far fault default not taken from strap");

    chk_polarity_follow: assert property (
        clock_enable && !port_soft_reset |=>
        tenbase_polarity_flag == $past(pol_s))
        else $error("polarity flag did not follow input");

    chk_soft_reset_keep: assert property (
        clock_enable && port_soft_reset && !wr_special_hi |=>
        $stable(crossover_source_select) && $stable(heartbeat_test_disable))
        else $error("soft reset disturbed kept bits");

    chk_cable_reset: assert property (
        @(posedge clock) disable iff (1'b0)
        $past(reset) |-> cable_length_estimate == 4'h0)
        else $error("cable estimate not zero after reset");

    chk_cable_gated: assert property (
        clock_enable && !cable_qualified |=> cable_length_estimate == 4'h0)
        else $error("estimate shown on unhealthy link");

    chk_reserved_zero: assert property (
        access_phase && !pwrite && clock_enable && !pready ##1
        pready |-> prdata[31:16] == 16'h0000 &&
        (prdata[15:0] & ~(pscl_pkg::PSCL_SPECIAL_USED |
        pscl_pkg::PSCL_CABLE_USED)) == 16'h0000)
        else $error("reserved bits read non-zero");

    chk_one_wait_state: assert property (
        clock_enable && access_phase && !pready |=> pready)
        else $error("access phase not answered in one wait state");

    cov_special_write: cover property (wr_special_hi && clock_enable);
    cov_cable_read: cover property (
        access_phase && pready && !pwrite && hit_cable);
    cov_unmapped: cover property (pready && pslverr);
    cov_soft_reset: cover property (port_soft_reset && clock_enable);

endmodule

// File: pscl_phy_model.sv
// Model of the PHY analog side that feeds status levels to the slice
`timescale 1ns/1ns
module pscl_phy_model
(
    input wire logic clock,
    input wire logic cfg_fx,
    input wire logic cfg_pol,
    input wire logic cfg_link,
    input wire logic cfg_spd,
    input wire logic cfg_fault,
    input wire logic [3:0] cfg_raw,
    output logic fx_mode,
    output logic rx_polarity_reversed,
    output logic link_up,
    output logic speed_100tx,
    output logic cable_fault,
    output logic [3:0] cable_length_raw
);
    ////////////////////////////////////////////////////////////////////////
    // Levels move just after an edge; raw estimate is driven even when
    // unqualified so that the slice's own gating is exercised
    always_ff @(posedge clock)
    begin
        fx_mode <= cfg_fx;
        rx_polarity_reversed <= cfg_pol;
        link_up <= cfg_link;
        speed_100tx <= cfg_spd;
        cable_fault <= cfg_fault;
        cable_length_raw <= cfg_raw;
    end
endmodule

// File: tb.sv
// Self-checking bench for the special control and cable length registers
`timescale 1ns/1ns
module tb;
    localparam logic [11:0] SP = pscl_pkg::PSCL_ADDR_SPECIAL;
    localparam logic [11:0] CB = pscl_pkg::PSCL_ADDR_CABLE;
    logic clock, reset, clock_enable, port_soft_reset;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, c_raw, cable_length_raw;
    logic c_fx, c_pol, c_link, c_spd, c_fault, err;
    logic fx_mode, rx_polarity_reversed, link_up, speed_100tx, cable_fault;
    logic heartbeat_test_active, far_fault_signalling, crossover_reserved;
    pscl_pkg::pscl_mdix_t crossover_mode;
    int failures, cmp_count, cycles;
    logic [15:0] mw [5] = '{16'h0000, 16'h8000, 16'hA000, 16'hC000,
        16'h2000};
    logic [1:0] me [5] = '{2'b10, 2'b00, 2'b01, 2'b10, 2'b10};

    pscl_phy_model phy (.clock(clock), .cfg_fx(c_fx), .cfg_pol(c_pol),
        .cfg_link(c_link), .cfg_spd(c_spd), .cfg_fault(c_fault),
        .cfg_raw(c_raw), .fx_mode(fx_mode),
        .rx_polarity_reversed(rx_polarity_reversed), .link_up(link_up),
        .speed_100tx(speed_100tx), .cable_fault(cable_fault),
        .cable_length_raw(cable_length_raw));

    pscl_regs dut (.clock(clock), .reset(reset),
        .clock_enable(clock_enable), .port_soft_reset(port_soft_reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fx_mode(fx_mode),
        .rx_polarity_reversed(rx_polarity_reversed), .link_up(link_up),
        .speed_100tx(speed_100tx), .cable_fault(cable_fault),
        .cable_length_raw(cable_length_raw),
        .crossover_mode(crossover_mode),
        .heartbeat_test_active(heartbeat_test_active),
        .far_fault_signalling(far_fault_signalling),
        .crossover_reserved(crossover_reserved));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the run needs well under a thousand cycles
    always #10 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparison helpers
    task automatic stop_test();
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; an idle edge first so no signal is set twice
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // pready ends this wait, or the bench timeout if it never rises; n counts wait states
        while (pready !== 1'b1)
        begin
            n++;
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("wait_states", 32'h1, 32'(n));
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
        apb(1'b1, a, d, s);
        repeat (3) @(posedge clock);
    endtask

    task automatic rd_chk(string name, logic [11:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk(name, exp, rd);
    endtask

    task automatic pulse(input logic chip);
        @(posedge clock);
        if (chip)
            reset <= 1'b1;
        else
            port_soft_reset <= 1'b1;
        repeat (chip ? 8 : 1) @(posedge clock);
        reset <= 1'b0;
        port_soft_reset <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        clock = 0;
        reset = 1;
        clock_enable = 1;
        port_soft_reset = 0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {c_fx, c_pol, c_link, c_spd, c_fault, c_raw} = '0;
        failures = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        repeat (3) @(posedge clock);
        chk("mode_rst", 32'h2, 32'(crossover_mode));
        chk("hb_rst", 32'h1, 32'(heartbeat_test_active));
        chk("ff_rst", 32'h0, 32'(far_fault_signalling));
        rd_chk("special_rst", SP, 32'h0);
        rd_chk("cable_rst", CB, 32'h0);
        // The three manual source/enable/state combinations plus source 0 with state 0 and 1
        for (int i = 0; i < 5; i++)
        begin
            wr(SP, {16'h0, mw[i]}, 4'hF);
            chk("mode", 32'(me[i]), 32'(crossover_mode));
            chk("resv", 32'h0, 32'(crossover_reserved));
            rd_chk("mode_rb", SP, {16'h0, mw[i]});
        end
        // Upper half and reserved bits are dropped
        wr(SP, 32'hFFFF_0820, 4'hF);
        chk("hb_off", 32'h0, 32'(heartbeat_test_active));
        chk("ff_on", 32'h1, 32'(far_fault_signalling));
        rd_chk("sp_upper", SP, 32'h0820);
        wr(SP, 32'h0000_17CF, 4'hF);
        rd_chk("sp_resv", SP, 32'h0);
        // Low lane only: crossover and heartbeat bits stay put
        wr(SP, 32'h0000_A820, 4'h1);
        rd_chk("lane0", SP, 32'h0020);
        c_pol <= 1'b1;
        repeat (5) @(posedge clock);
        rd_chk("polarity", SP, 32'h0030);
        c_pol <= 1'b0;
        // Cable estimate only while qualified
        c_link <= 1'b1;
        c_spd <= 1'b1;
        c_raw <= 4'hB;
        repeat (5) @(posedge clock);
        rd_chk("cable", CB, 32'hB000);
        wr(CB, 32'h0000_0800, 4'hF);
        rd_chk("cable_wr", CB, 32'hB000);
        c_fault <= 1'b1;
        repeat (5) @(posedge clock);
        rd_chk("cable_fault", CB, 32'h0);
        c_fault <= 1'b0;
        c_spd <= 1'b0;
        repeat (5) @(posedge clock);
        rd_chk("cable_10t", CB, 32'h0);
        // Soft reset keeps crossover and heartbeat, restores far fault
        wr(SP, 32'h0000_A820, 4'hF);
        pulse(1'b0);
        rd_chk("soft", SP, 32'hA800);
        chk("soft_mode", 32'h1, 32'(crossover_mode));
        // Chip reset with fiber strap
        c_fx <= 1'b1;
        pulse(1'b1);
        chk("ff_fx", 32'h1, 32'(far_fault_signalling));
        rd_chk("chip", SP, 32'h0020);
        wr(SP, 32'h0000_8000, 4'hF);
        chk("fx_mode", 32'h0, 32'(crossover_mode));
        pulse(1'b0);
        rd_chk("soft_fx", SP, 32'h8020);
        // Frozen clock enable must swallow a soft reset pulse
        wr(SP, 32'h0000_8000, 4'h1);
        chk("ff_wr0", 32'h0, 32'(far_fault_signalling));
        clock_enable <= 1'b0;
        pulse(1'b0);
        clock_enable <= 1'b1;
        repeat (3) @(posedge clock);
        chk("frozen_ff", 32'h0, 32'(far_fault_signalling));
        apb(1'b0, 12'h100, 32'h0, 4'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_rd", 32'h0, rd);
        stop_test();
    end
endmodule
